//--- shared/nco_pkg.sv
// constants and types for the phase accumulator oscillator
//------------------------------------------------------------
//------------------------------------------------------------
package nco_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int ACC_W = 20;
  localparam int INC_W = 16;
  localparam int EXT_SRC_N = 3;
  localparam int SRC_FAST = 0;
  localparam int SRC_LOGIC = 1;
  localparam int SRC_PIN = 2;
  localparam logic [ADDR_W-1:0] OFF_ACC_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_ACC_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_ACC_UPPER = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_INC_LOW = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_INC_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CONTROL = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h8;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_PIN_EN_BIT = 6;
  localparam int CTRL_LEVEL_BIT = 5;
  localparam int CTRL_POLARITY_BIT = 4;
  localparam int CTRL_MODE_BIT = 0;
  localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'hd1;
  localparam int CLK_SEL_LSB = 0;
  localparam int CLK_SEL_W = 3;
  localparam int PW_LSB = 5;
  localparam int PW_W = 3;
  localparam int PW_CNT_W = 8;
  localparam logic [DATA_W-1:0] CLK_WR_MASK = 8'he7;
  localparam int IRQ_OVF_BIT = 0;
  localparam logic [DATA_W-1:0] IRQ_WR_MASK = 8'h01;
  localparam logic [CLK_SEL_W-1:0] CKS_FAST_OSC = 3'h0;
  localparam logic [CLK_SEL_W-1:0] CKS_SYS = 3'h1;
  localparam logic [CLK_SEL_W-1:0] CKS_LOGIC_CELL = 3'h2;
  localparam logic [CLK_SEL_W-1:0] CKS_EXT_PIN = 3'h3;
  localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
  typedef enum logic [1:0] {XFER_IDLE, XFER_ARMED, XFER_ONE_EDGE} xfer_state_type;
endpackage

//--- shared/shaper_if.sv
// signals between the oscillator core and its output shaper
interface shaper_if;
  logic carry_pulse;
  logic clock_edge;
  logic enable;
  logic pulse_mode;
  logic polarity;
  logic [nco_pkg::PW_W-1:0] width_sel;
  logic shaped;
  modport ctrl (output carry_pulse, clock_edge, enable, pulse_mode, polarity, width_sel, input shaped);
  modport shaper (input carry_pulse, clock_edge, enable, pulse_mode, polarity, width_sel, output shaped);
endinterface

//--- rtl/input_clock_sync.sv
// input clock source synchroniser, selector and rising edge detector
module input_clock_sync (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [nco_pkg::EXT_SRC_N-1:0] raw_clocks_in,
  input wire logic [nco_pkg::CLK_SEL_W-1:0] select_in,
  output logic edge_out
);
  import nco_pkg::*;

  logic [EXT_SRC_N-1:0] meta_r;
  logic [EXT_SRC_N-1:0] sync_r;
  logic sel_level;
  logic prev_r;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw_clocks_in;
      sync_r <= meta_r;
    end
  end

  always_comb begin
    case (select_in)
      CKS_FAST_OSC: sel_level = sync_r[SRC_FAST];
      CKS_LOGIC_CELL: sel_level = sync_r[SRC_LOGIC];
      CKS_EXT_PIN: sel_level = sync_r[SRC_PIN];
      default: sel_level = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) prev_r <= 1'b0;
    else prev_r <= sel_level;
  end

  // system clock source steps on every cycle
  assign edge_out = (select_in == CKS_SYS) ? 1'b1 : (sel_level & ~prev_r);
endmodule // input_clock_sync

//--- rtl/output_shaper.sv
// output shaper: toggle or stretched pulse, then polarity
module output_shaper (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  shaper_if.shaper sh
);
  import nco_pkg::*;

  logic toggle_r;
  logic pulse_r;
  logic [PW_CNT_W-1:0] pulse_cnt_r;
  logic shaped_r;

  function automatic logic [PW_CNT_W-1:0] pulse_len(input logic [PW_W-1:0] sel);
    pulse_len = PW_CNT_W'(1) << sel;
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || !sh.enable) toggle_r <= 1'b0;
    else if (sh.carry_pulse) toggle_r <= ~toggle_r;
  end

  // pulse lasts 2**width_sel input clock periods
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || !sh.enable) begin
      pulse_r <= 1'b0;
      pulse_cnt_r <= '0;
    end else if (sh.carry_pulse) begin
      pulse_r <= 1'b1;
      pulse_cnt_r <= pulse_len(sh.width_sel);
    end else if (pulse_r && sh.clock_edge) begin
      pulse_cnt_r <= pulse_cnt_r - PW_CNT_W'(1);
      if (pulse_cnt_r == PW_CNT_W'(1)) pulse_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) shaped_r <= 1'b0;
    else shaped_r <= (sh.pulse_mode ? pulse_r : toggle_r) ^ sh.polarity;
  end

  assign sh.shaped = shaped_r;
endmodule // output_shaper

//--- rtl/nco_top.sv
// numerically controlled oscillator with register port and interrupt
module nco_top #(
  parameter int ACC_W = nco_pkg::ACC_W,
  parameter int INC_W = nco_pkg::INC_W
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [nco_pkg::ADDR_W-1:0] addr_in,
  input wire logic [nco_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [nco_pkg::DATA_W-1:0] rdata_out,
  input wire logic fast_internal_osc_in,
  input wire logic logic_cell_one_output_in,
  input wire logic external_clock_pin_in,
  output logic accum_carry_out,
  output logic periph_out,
  output logic pin_out,
  output logic pin_oe_out,
  output logic overflow_irq_out
);
  import nco_pkg::*;

  //------------------------------------------------------------
  // declarations
  //------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] clk_ctl_r;
  logic [DATA_W-1:0] inc_low_r;
  logic [DATA_W-1:0] inc_high_r;
  logic [DATA_W-1:0] inc_low_nxt;
  logic [DATA_W-1:0] inc_high_nxt;
  logic [INC_W-1:0] inc_buf_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W:0] sum_w;
  logic carry_r;
  logic [DATA_W-1:0] irq_stat_r;
  logic [DATA_W-1:0] irq_mask_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  xfer_state_type xfer_state_r;
  xfer_state_type xfer_nxt;
  logic load_now;
  logic clk_edge;
  logic enabled;
  logic add_now;
  logic overflow_evt;
  logic wr_inc_low;
  logic wr_inc_high;
  logic shaped_level;

  shaper_if sh_bus ();

  //------------------------------------------------------------
  // address decode
  //------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction

  assign enabled = ctrl_r[CTRL_ENABLE_BIT];
  assign wr_inc_low = wr_in && hit(addr_in, OFF_INC_LOW);
  assign wr_inc_high = wr_in && hit(addr_in, OFF_INC_HIGH);

  //------------------------------------------------------------
  // input clock selection
  //------------------------------------------------------------
  input_clock_sync u_clock_sync (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .raw_clocks_in({external_clock_pin_in, logic_cell_one_output_in, fast_internal_osc_in}),
    .select_in(clk_ctl_r[CLK_SEL_LSB +: CLK_SEL_W]),
    .edge_out(clk_edge)
  );

  //------------------------------------------------------------
  // control registers
  //------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ctrl_r <= BYTE_RESET;
    end else if (wr_in && hit(addr_in, OFF_CONTROL)) begin
      ctrl_r <= wdata_in & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      clk_ctl_r <= BYTE_RESET;
    end else if (wr_in && hit(addr_in, OFF_CLOCK_CONTROL)) begin
      clk_ctl_r <= wdata_in & CLK_WR_MASK;
    end
  end

  //------------------------------------------------------------
  // increment registers
  //------------------------------------------------------------
  always_comb begin
    inc_low_nxt = inc_low_r;
    inc_high_nxt = inc_high_r;
    if (wr_inc_low) inc_low_nxt = wdata_in;
    if (wr_inc_high) inc_high_nxt = wdata_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      inc_low_r <= BYTE_RESET;
      inc_high_r <= BYTE_RESET;
    end else begin
      inc_low_r <= inc_low_nxt;
      inc_high_r <= inc_high_nxt;
    end
  end

  //------------------------------------------------------------
  // increment transfer sequencer
  //------------------------------------------------------------
  always_comb begin
    xfer_nxt = xfer_state_r;
    load_now = 1'b0;
    case (xfer_state_r)
      XFER_IDLE: begin
        xfer_nxt = XFER_IDLE;
      end
      XFER_ARMED: begin
        if (clk_edge) xfer_nxt = XFER_ONE_EDGE;
      end
      XFER_ONE_EDGE: begin
        if (clk_edge) begin
          xfer_nxt = XFER_IDLE;
          load_now = 1'b1;
        end
      end
      default: begin
        xfer_nxt = XFER_IDLE;
      end
    endcase
    if (!enabled) begin
      xfer_nxt = XFER_IDLE;
      load_now = 1'b0;
    end else if (wr_inc_low) begin
      xfer_nxt = XFER_ARMED;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) xfer_state_r <= XFER_IDLE;
    else xfer_state_r <= xfer_nxt;
  end

  // hidden buffer, never on the read port
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      inc_buf_r <= '0;
    end else if (!enabled && (wr_inc_low || wr_inc_high)) begin
      inc_buf_r <= INC_W'({inc_high_nxt, inc_low_nxt});
    end else if (load_now) begin
      inc_buf_r <= INC_W'({inc_high_r, inc_low_r});
    end
  end

  //------------------------------------------------------------
  // accumulator and adder
  //------------------------------------------------------------
  assign add_now = enabled && clk_edge;
  assign sum_w = {1'b0, acc_r} + (ACC_W + 1)'(inc_buf_r);
  assign overflow_evt = add_now && sum_w[ACC_W];

  always_comb begin
    acc_nxt = acc_r;
    if (add_now) acc_nxt = sum_w[ACC_W-1:0];
    if (wr_in && hit(addr_in, OFF_ACC_LOW)) acc_nxt[DATA_W-1:0] = wdata_in;
    if (wr_in && hit(addr_in, OFF_ACC_HIGH)) acc_nxt[2*DATA_W-1:DATA_W] = wdata_in;
    if (wr_in && hit(addr_in, OFF_ACC_UPPER)) acc_nxt[ACC_W-1:2*DATA_W] = wdata_in[ACC_W-2*DATA_W-1:0];
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) acc_r <= '0;
    else acc_r <= acc_nxt;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) carry_r <= 1'b0;
    else carry_r <= overflow_evt;
  end

  //------------------------------------------------------------
  // interrupt status and mask
  //------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      irq_stat_r <= BYTE_RESET;
    end else begin
      if (wr_in && hit(addr_in, OFF_IRQ_STATUS)) begin
        irq_stat_r <= irq_stat_r & ~(wdata_in & IRQ_WR_MASK);
      end
      if (overflow_evt) irq_stat_r[IRQ_OVF_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) irq_mask_r <= BYTE_RESET;
    else if (wr_in && hit(addr_in, OFF_IRQ_MASK)) irq_mask_r <= wdata_in & IRQ_WR_MASK;
  end

  assign overflow_irq_out = |(irq_stat_r & irq_mask_r);

  //------------------------------------------------------------
  // output shaping
  //------------------------------------------------------------
  assign sh_bus.carry_pulse = overflow_evt;
  assign sh_bus.clock_edge = clk_edge;
  assign sh_bus.enable = enabled;
  assign sh_bus.pulse_mode = ctrl_r[CTRL_MODE_BIT];
  assign sh_bus.polarity = ctrl_r[CTRL_POLARITY_BIT];
  assign sh_bus.width_sel = clk_ctl_r[PW_LSB +: PW_W];
  assign shaped_level = sh_bus.shaped;

  output_shaper u_shaper (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .sh(sh_bus)
  );

  assign accum_carry_out = carry_r;
  assign periph_out = shaped_level;
  assign pin_out = shaped_level;
  assign pin_oe_out = ctrl_r[CTRL_PIN_EN_BIT];

  //------------------------------------------------------------
  // read port
  //------------------------------------------------------------
  always_comb begin
    rdata_nxt = BYTE_RESET;
    if (rd_in) begin
      case (addr_in)
        OFF_ACC_LOW: rdata_nxt = acc_r[DATA_W-1:0];
        OFF_ACC_HIGH: rdata_nxt = acc_r[2*DATA_W-1:DATA_W];
        OFF_ACC_UPPER: rdata_nxt = DATA_W'(acc_r[ACC_W-1:2*DATA_W]);
        OFF_INC_LOW: rdata_nxt = inc_low_r;
        OFF_INC_HIGH: rdata_nxt = inc_high_r;
        OFF_CONTROL: begin
          rdata_nxt = ctrl_r;
          rdata_nxt[CTRL_LEVEL_BIT] = shaped_level;
        end
        OFF_CLOCK_CONTROL: rdata_nxt = clk_ctl_r;
        OFF_IRQ_STATUS: rdata_nxt = irq_stat_r;
        OFF_IRQ_MASK: rdata_nxt = irq_mask_r;
        default: rdata_nxt = BYTE_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) rdata_r <= BYTE_RESET;
    else rdata_r <= rdata_nxt;
  end

  assign rdata_out = rdata_r;
endmodule // nco_top

//--- test/nco_monitor.sv
// port checker for the phase accumulator oscillator
module nco_monitor #(
  parameter int ACC_W = nco_pkg::ACC_W,
  parameter int INC_W = nco_pkg::INC_W
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [nco_pkg::ADDR_W-1:0] addr_in,
  input wire logic [nco_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [nco_pkg::DATA_W-1:0] rdata_out,
  input wire logic accum_carry_out,
  input wire logic periph_out,
  input wire logic pin_out,
  input wire logic pin_oe_out,
  input wire logic overflow_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import nco_pkg::*;
  logic [DATA_W-1:0] ctrl_r;
  logic en;
  logic fdc;
  // shadow of the control register
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      ctrl_r <= 8'h00;
    end else if (wr_in && addr_in == OFF_CONTROL) begin
      ctrl_r <= wdata_in & CTRL_WR_MASK;
    end
  end
  assign en = ctrl_r[CTRL_ENABLE_BIT];
  assign fdc = en && !ctrl_r[CTRL_MODE_BIT];
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  AST_RD_IDLE:
    assert property (!$past(rd_in) |-> rdata_out == 8'h00) else $error("read data not idle");
  AST_CARRY_ONE:
    assert property (accum_carry_out |=> !accum_carry_out) else $error("carry too long");
  AST_IRQ_RISE:
    assert property ($rose(overflow_irq_out) |-> accum_carry_out || $past(wr_in)) else $error("irq without cause");
  AST_IRQ_FALL:
    assert property ($fell(overflow_irq_out) |-> $past(wr_in)) else $error("irq dropped alone");
  AST_CARRY_OFF:
    assert property (!en && !$past(wr_in) && !$past(wr_in, 2) |-> !accum_carry_out) else $error("carry while off");
  AST_IDLE_LEVEL:
    assert property (!en && !$past(wr_in) && !$past(wr_in, 2) |-> periph_out == ctrl_r[CTRL_POLARITY_BIT])
      else $error("idle level wrong");
  AST_OE_CTRL:
    assert property (!$past(wr_in) |-> pin_oe_out == ctrl_r[CTRL_PIN_EN_BIT]) else $error("pin enable wrong");
  AST_PIN_COPY:
    assert property (pin_oe_out |-> pin_out == periph_out || pin_out == $past(periph_out))
      else $error("pin differs");
  AST_FDC_TOGGLE:
    assert property (fdc && accum_carry_out && !wr_in && !$past(wr_in) |=> $changed(periph_out))
      else $error("no toggle");
  AST_FDC_HOLD:
    assert property (fdc && !accum_carry_out && !wr_in && !$past(wr_in) |=> $stable(periph_out))
      else $error("spurious toggle");
endmodule // nco_monitor

bind nco_top nco_monitor #(.ACC_W(ACC_W), .INC_W(INC_W)) i_mon (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .accum_carry_out(accum_carry_out), .periph_out(periph_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .overflow_irq_out(overflow_irq_out));

//--- test/periph_receiver.sv
// model of a peripheral counting rising edges of the shaped output
module periph_receiver (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic shaped_in,
  output logic [15:0] rises_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_r;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      last_r <= 1'b0;
      rises_out <= 16'h0000;
    end else begin
      last_r <= shaped_in;
      if (shaped_in && !last_r) begin
        rises_out <= rises_out + 16'h0001;
      end
    end
  end
endmodule // periph_receiver

//--- test/tb_top.sv
// self-checking testbench for the phase accumulator oscillator
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import nco_pkg::*;
  logic clk_sys_in, resetn_in, wr_in, rd_in, accum_carry_out, periph_out, pin_out, pin_oe_out, overflow_irq_out;
  logic fast_internal_osc_in, logic_cell_one_output_in, external_clock_pin_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in, rdata_out, b, ctl, k2;
  logic [DATA_W-1:0] v[8];
  logic [15:0] k, rises;
  logic [19:0] a0, acc;
  logic [31:0] delta;
  int i, j, seed, c0, r0, ct, t0, n, e, cyc, carries, n_fail, checks;

  nco_top i_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .fast_internal_osc_in(fast_internal_osc_in),
    .logic_cell_one_output_in(logic_cell_one_output_in), .external_clock_pin_in(external_clock_pin_in),
    .accum_carry_out(accum_carry_out), .periph_out(periph_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .overflow_irq_out(overflow_irq_out));
  periph_receiver i_rx (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .shaped_in(periph_out),
    .rises_out(rises));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // slow sources, carry count, timeout
  always @(posedge clk_sys_in) begin
    cyc++;
    fast_internal_osc_in <= (cyc % 6) < 3;
    logic_cell_one_output_in <= ((cyc + 2) % 6) < 3;
    external_clock_pin_in <= ((cyc + 4) % 6) < 3;
    if (accum_carry_out === 1'b1) carries++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  function automatic int exp_rises(int sel, int c);
    return sel % 2 ? c : (c + 1) / 2;
  endfunction

  initial begin
    seed = 86716;
    {resetn_in, wr_in, rd_in, fast_internal_osc_in, logic_cell_one_output_in, external_clock_pin_in} = 6'h00;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    repeat (16) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    for (i = 0; i < 10; i++) begin
      if (i == 9) wr(4'h9, 8'hff);
      rd(4'(i), b);
      chk(20'(b), 20'h0);
    end
    wr(OFF_IRQ_MASK, 8'h01);
    for (i = 0; i < 5; i++) begin
      k = 16'h8000 | 16'($random(seed));
      a0 = 20'($random(seed));
      ctl = {1'b0, i[1], 1'b0, i[0], 3'h0, i[0]};
      wr(OFF_INC_HIGH, k[15:8]);
      wr(OFF_INC_LOW, k[7:0]);
      wr(OFF_ACC_LOW, a0[7:0]);
      wr(OFF_ACC_HIGH, a0[15:8]);
      wr(OFF_ACC_UPPER, {4'h0, a0[19:16]});
      rd(OFF_INC_HIGH, b);
      chk(20'(b), 20'(k[15:8]));
      rd(OFF_ACC_UPPER, b);
      chk(20'(b), 20'(a0[19:16]));
      wr(OFF_CLOCK_CONTROL, 8'(i) | ((i == 3) ? 8'h40 : 8'h00));
      wr(OFF_CONTROL, ctl);
      wr(OFF_IRQ_STATUS, 8'h01);
      repeat (4) @(posedge clk_sys_in);
      c0 = carries;
      r0 = rises;
      wr(OFF_CONTROL, ctl | 8'h80);
      t0 = cyc;
      chk(20'(pin_oe_out), 20'(i[1]));
      repeat (1200) @(posedge clk_sys_in);
      for (j = 0; j < 400 && accum_carry_out !== 1'b1; j++) @(posedge clk_sys_in);
      repeat ((i == 3) ? 40 : 12) @(posedge clk_sys_in);
      chk(20'(rises - 16'(r0)), 20'(exp_rises(i, carries - c0)));
      wr(OFF_CONTROL, ctl);
      e = (i == 4) ? 0 : (cyc - t0) / ((i == 1) ? 1 : 6);
      repeat (4) @(posedge clk_sys_in);
      ct = carries - c0;
      rd(OFF_ACC_LOW, acc[7:0]);
      rd(OFF_ACC_HIGH, acc[15:8]);
      rd(OFF_ACC_UPPER, b);
      acc[19:16] = b[3:0];
      delta = 32'(ct) * 32'h100000 + 32'(acc) - 32'(a0);
      n = delta / 32'(k);
      chk(20'(delta % 32'(k)), 20'h0);
      chk(20'(n >= e - 3 && n <= e + 3), 20'h1);
      if (i == 3) wr(OFF_IRQ_MASK, 8'h00);
      rd(OFF_IRQ_STATUS, b);
      chk(20'(b), 20'(ct != 0));
      chk(20'(overflow_irq_out), 20'(ct != 0 && i != 3));
      wr(OFF_IRQ_STATUS, 8'h01);
      wr(OFF_IRQ_MASK, 8'h01);
      chk(20'(overflow_irq_out), 20'h0);
    end
    k = 16'($random(seed)) & 16'h007f | 16'h0001;
    k2 = 8'h80 | 8'($random(seed));
    wr(OFF_INC_HIGH, 8'h00);
    wr(OFF_INC_LOW, k[7:0]);
    wr(OFF_CLOCK_CONTROL, 8'(CKS_SYS));
    wr(OFF_CONTROL, 8'h80);
    wr(OFF_INC_HIGH, 8'h00);
    @(posedge clk_sys_in);
    addr_in <= OFF_INC_LOW;
    wdata_in <= k2;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= OFF_ACC_LOW;
    for (j = 0; j < 8; j++) begin
      @(posedge clk_sys_in);
      #1;
      v[j] = rdata_out;
    end
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    chk(20'(8'(v[1] - v[0])), 20'(k[7:0]));
    chk(20'(8'(v[2] - v[1])), 20'(k[7:0]));
    chk(20'(8'(v[3] - v[2])), 20'(k2));
    chk(20'(8'(v[7] - v[6])), 20'(k2));
    finish_test();
  end
endmodule // tb_top
